// ### mfr_responder.sv
// modbus rtu read responder for the averaged co2 float
// assumes byte-level rx/tx from a uart and a frame_end pulse from gap detection
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - The block answers as station 0x43 unless another station number is configured.
// - A function 03 read of two registers at 0x424 returns both words of the co2 float.
// - The returned value is the ieee754 single-precision word given on the input unchanged.
// - The two 16-bit halves of the float are swapped on the bus, low half first.
// - The first register holds float bytes three then four, the low mantissa bits.
// - The second register holds sign and exponent then exponent lsb and top mantissa.
module mfr_responder
  import mfr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        station_cfg_en,
  input  wire logic [7:0]  station_cfg,
  input  wire logic [31:0] co2_mean_float,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        frame_end,
  input  wire logic        tx_ready,
  output logic             tx_valid,
  output logic [7:0]       tx_byte
);

  mfr_regs_t   r;
  mfr_regs_t   next_r;
  logic [7:0]  station;
  logic [15:0] crc_tmp;

  // request fields
  logic [7:0]  req_addr;
  logic [7:0]  req_fc;
  logic [15:0] req_start;
  logic [15:0] req_qty;

  // handshake qualifiers
  logic        rx_take;
  logic        end_take;
  logic        tx_take;

  // acceptance checks
  logic        len_ok;
  logic        crc_ok;
  logic        addr_ok;
  logic        fc_ok;
  logic        range_ok;
  logic        req_good;

  // reply walk
  logic [3:0]  next_idx;
  logic        last_data;
  logic [7:0]  data_byte;

  // one bit of the reflected crc-16 shift
  function automatic logic [15:0] crc_shift(input logic [15:0] c);
    logic [15:0] s;
    s = c >> 1;
    if (c[0]) begin
      s = s ^ CRC_POLY;
    end
    return s;
  endfunction

  // crc-16 update with one byte, lsb first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      x = crc_shift(x);
    end
    return x;
  endfunction

  // exception body: station, flagged function code, reason
  function automatic mfr_regs_t fill_exc(input mfr_regs_t s, input logic [7:0] sta,
                                         input logic [7:0] fc, input logic [7:0] code);
    mfr_regs_t o;
    o           = s;
    o.tx_buf[0] = sta;
    o.tx_buf[1] = fc | FC_EXC_FLAG;
    o.tx_buf[2] = code;
    o.tx_len    = EXC_DATA_LEN;
    return o;
  endfunction

  // normal body: both float registers, low half first
  function automatic mfr_regs_t fill_float(input mfr_regs_t s, input logic [7:0] sta,
                                           input logic [31:0] f);
    mfr_regs_t o;
    o           = s;
    o.tx_buf[0] = sta;
    o.tx_buf[1] = FC_READ_HOLD;
    o.tx_buf[2] = FLOAT_BYTES;
    o.tx_buf[3] = f[15:8];
    o.tx_buf[4] = f[7:0];
    o.tx_buf[5] = f[31:24];
    o.tx_buf[6] = f[23:16];
    o.tx_len    = RESP_DATA_LEN;
    return o;
  endfunction

  // reply start: station byte shown first, crc restarted
  function automatic mfr_regs_t start_reply(input mfr_regs_t s, input logic [7:0] sta);
    mfr_regs_t o;
    o          = s;
    o.st       = mfr_tx_data;
    o.tx_idx   = 4'h0;
    o.tx_valid = 1'b1;
    o.tx_byte  = sta;
    o.crc      = CRC_INIT;
    o.rx_cnt   = RX_EMPTY;
    return o;
  endfunction

  // back to listening with an empty receiver
  function automatic mfr_regs_t go_idle(input mfr_regs_t s);
    mfr_regs_t o;
    o          = s;
    o.st       = mfr_rx;
    o.tx_valid = 1'b0;
    o.tx_byte  = TX_IDLE_BYTE;
    o.crc      = CRC_INIT;
    o.rx_cnt   = RX_EMPTY;
    o.tx_idx   = 4'h0;
    return o;
  endfunction

  assign station   = station_cfg_en ? station_cfg : STATION_DEFAULT;
  assign req_addr  = r.rx_buf[0];
  assign req_fc    = r.rx_buf[1];
  assign req_start = {r.rx_buf[2], r.rx_buf[3]};
  assign req_qty   = {r.rx_buf[4], r.rx_buf[5]};

  assign rx_take   = (r.st == mfr_rx) && rx_valid;
  assign end_take  = (r.st == mfr_rx) && !rx_valid && frame_end;
  assign tx_take   = (r.st != mfr_rx) && tx_ready;

  assign len_ok    = (r.rx_cnt == REQ_LEN);
  // residue of zero over body plus crc means the crc is good
  assign crc_ok    = (r.crc == CRC_RESIDUE);
  assign addr_ok   = (req_addr == station);
  assign fc_ok     = (req_fc == FC_READ_HOLD);
  assign range_ok  = (req_start == REG_CO2_MEAN) && (req_qty == FLOAT_QTY);
  assign req_good  = len_ok && crc_ok && addr_ok;

  assign next_idx  = r.tx_idx + 4'h1;
  assign last_data = (next_idx >= r.tx_len);
  assign data_byte = r.tx_buf[next_idx[2:0]];

  always_comb begin
    next_r  = r;
    crc_tmp = crc_byte(r.crc, r.tx_byte);
    case (r.st)
      mfr_rx: begin
        if (rx_take) begin
          if (r.rx_cnt < REQ_LEN) begin
            next_r.rx_buf[r.rx_cnt[2:0]] = rx_byte;
            next_r.rx_cnt                = r.rx_cnt + 4'h1;
            next_r.crc                   = crc_byte(r.crc, rx_byte);
          end else begin
            next_r.rx_cnt = RX_OVERLONG;
          end
        end else if (end_take) begin
          next_r.rx_cnt = RX_EMPTY;
          next_r.crc    = CRC_INIT;
          if (req_good) begin
            if (!fc_ok) begin
              next_r = fill_exc(next_r, station, req_fc, EXC_BAD_FUNC);
            end else if (!range_ok) begin
              next_r = fill_exc(next_r, station, FC_READ_HOLD, EXC_BAD_ADDR);
            end else begin
              // float captured once so both halves belong to one sample
              next_r = fill_float(next_r, station, co2_mean_float);
            end
            next_r = start_reply(next_r, station);
          end
        end
      end
      mfr_tx_data: begin
        if (tx_take) begin
          next_r.crc    = crc_tmp;
          next_r.tx_idx = next_idx;
          if (last_data) begin
            next_r.st      = mfr_tx_crc_lo;
            next_r.tx_byte = crc_tmp[7:0];
          end else begin
            next_r.tx_byte = data_byte;
          end
        end
      end
      mfr_tx_crc_lo: begin
        // low crc byte on the line, high byte next
        if (tx_take) begin
          next_r.st      = mfr_tx_crc_hi;
          next_r.tx_byte = r.crc[15:8];
        end
      end
      mfr_tx_crc_hi: begin
        if (tx_take) begin
          next_r = go_idle(r);
        end
      end
      default: begin
        next_r = go_idle(r);
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r <= REGS_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign tx_valid = r.tx_valid;
  assign tx_byte  = r.tx_byte;

endmodule

`default_nettype wire

// ### mfr_pkg.sv
// constants and types for the modbus float reading responder
// assumes a byte-level rs485 front end outside this block
package mfr_pkg;

  localparam logic [7:0]  STATION_DEFAULT = 8'h43;
  localparam logic [7:0]  FC_READ_HOLD    = 8'h03;
  localparam logic [7:0]  FC_EXC_FLAG     = 8'h80;
  localparam logic [7:0]  EXC_BAD_FUNC    = 8'h01;
  localparam logic [7:0]  EXC_BAD_ADDR    = 8'h02;
  localparam logic [15:0] REG_CO2_MEAN    = 16'h0424;
  localparam logic [15:0] FLOAT_QTY       = 16'h0002;
  localparam logic [7:0]  FLOAT_BYTES     = 8'h04;
  localparam logic [15:0] CRC_INIT        = 16'hffff;
  localparam logic [15:0] CRC_POLY        = 16'ha001;
  localparam logic [3:0]  REQ_LEN         = 4'h8;
  localparam logic [3:0]  RX_OVERLONG     = 4'h9;
  localparam logic [3:0]  RESP_DATA_LEN   = 4'h7;
  localparam logic [3:0]  EXC_DATA_LEN    = 4'h3;
  localparam logic [3:0]  RX_EMPTY        = 4'h0;
  localparam logic [7:0]  TX_IDLE_BYTE    = 8'h00;
  localparam logic [15:0] CRC_RESIDUE     = 16'h0000;

  typedef enum logic [1:0] {
    mfr_rx,
    mfr_tx_data,
    mfr_tx_crc_lo,
    mfr_tx_crc_hi
  } mfr_state_t;

  typedef struct packed {
    mfr_state_t      st;
    logic [3:0]      rx_cnt;
    logic [7:0][7:0] rx_buf;
    logic [15:0]     crc;
    logic [6:0][7:0] tx_buf;
    logic [3:0]      tx_idx;
    logic [3:0]      tx_len;
    logic            tx_valid;
    logic [7:0]      tx_byte;
  } mfr_regs_t;

  localparam mfr_regs_t REGS_RESET = '{
    st:       mfr_rx,
    rx_cnt:   RX_EMPTY,
    rx_buf:   '0,
    crc:      CRC_INIT,
    tx_buf:   '0,
    tx_idx:   4'h0,
    tx_len:   4'h0,
    tx_valid: 1'b0,
    tx_byte:  TX_IDLE_BYTE
  };

endpackage

// ### mfr_responder_properties.sv
// port checks for the responder
// bound to every mfr_responder
`timescale 1ns/1ps
`default_nettype none
module mfr_responder_properties
  import mfr_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       station_cfg_en,
  input wire logic [7:0] station_cfg,
  input wire logic       frame_end,
  input wire logic       tx_ready,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_byte
);
  logic [3:0] taken_cnt;
  logic [7:0] fc_sent;
  // bytes accepted so far in the running reply, and its function byte
  always_ff @(posedge ref_clk) begin
    if (rst || !tx_valid) begin
      taken_cnt <= 4'h0;
      fc_sent   <= 8'h00;
    end else if (tx_ready) begin
      taken_cnt <= taken_cnt + 4'h1;
      if (taken_cnt == 4'h1) begin
        fc_sent <= tx_byte;
      end
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_start; !tx_valid ##1 tx_valid; endsequence
  sequence s_third; tx_valid && taken_cnt == 4'h2; endsequence
  property p_station;
    s_start |-> ($past(station_cfg_en) && tx_byte == $past(station_cfg))
             || (!$past(station_cfg_en) && tx_byte == STATION_DEFAULT);
  endproperty
  a_station: assert property (p_station) else $error("bad station");
  property p_cause; !tx_valid && !frame_end |=> !tx_valid; endproperty
  a_cause: assert property (p_cause) else $error("unasked reply");
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte); endproperty
  a_hold: assert property (p_hold) else $error("byte lost");
  property p_end; $fell(tx_valid) |-> $past(tx_ready); endproperty
  a_end: assert property (p_end) else $error("early end");
  property p_reset; disable iff (1'b0) rst |=> !tx_valid && tx_byte == TX_IDLE_BYTE; endproperty
  a_reset: assert property (p_reset) else $error("reply during reset");
  property p_length; $fell(tx_valid) |-> $past(taken_cnt) == 4'h8 || $past(taken_cnt) == 4'h4;
  endproperty
  a_length: assert property (p_length) else $error("reply length");
  property p_field; s_third ##0 (fc_sent == FC_READ_HOLD) |-> tx_byte == FLOAT_BYTES; endproperty
  a_field: assert property (p_field) else $error("byte count field");
  property p_reason;
    s_third ##0 fc_sent[7] |-> tx_byte == EXC_BAD_FUNC || tx_byte == EXC_BAD_ADDR;
  endproperty
  a_reason: assert property (p_reason) else $error("exception code");
endmodule
bind mfr_responder mfr_responder_properties u_props (.ref_clk(ref_clk), .rst(rst),
  .station_cfg_en(station_cfg_en), .station_cfg(station_cfg), .frame_end(frame_end),
  .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte));
`default_nettype wire

// ### mfr_master_model.sv
// bus master: sends request frames, takes reply bytes
// drives on the falling edge of ref_clk
`timescale 1ns/1ps
`default_nettype none
module mfr_master_model (
  input  wire logic       ref_clk,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  output logic            rx_valid,
  output logic [7:0]      rx_byte,
  output logic            frame_end,
  output logic            tx_ready
);
  logic [7:0] got[$];
  initial begin rx_valid = 0; rx_byte = 8'h00; frame_end = 0; tx_ready = 0; end
  always @(negedge ref_clk) tx_ready <= ~tx_ready;
  always @(posedge ref_clk) if (tx_valid && tx_ready) got.push_back(tx_byte);
  // whole frame of the bytes given, then one frame_end pulse
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i]) begin @(negedge ref_clk); rx_valid <= 1; rx_byte <= f[i]; end
    @(negedge ref_clk); rx_valid <= 0; rx_byte <= ~rx_byte; frame_end <= 1;
    @(negedge ref_clk); frame_end <= 0;
  endtask
endmodule
`default_nettype wire

// ### tb_modbus_float_reading_responder.sv
// self-checking bench for the responder
// uses mfr_master_model as bus master
`timescale 1ns/1ps
`default_nettype none
module tb_modbus_float_reading_responder
  import mfr_pkg::*;
;
  logic ref_clk, rst, station_cfg_en, rx_valid, frame_end, tx_ready, tx_valid;
  logic [7:0] station_cfg, rx_byte, tx_byte;
  logic [31:0] co2_mean_float;
  int mismatches = 0, tests_run = 0;
  mfr_responder u_dut (.ref_clk(ref_clk), .rst(rst), .station_cfg_en(station_cfg_en),
    .station_cfg(station_cfg), .co2_mean_float(co2_mean_float), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .frame_end(frame_end), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_byte(tx_byte));
  mfr_master_model u_host (.ref_clk(ref_clk), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .frame_end(frame_end), .tx_ready(tx_ready));
  initial begin ref_clk = 0; forever #12.5 ref_clk = ~ref_clk; end
  function automatic void add_crc(ref logic [7:0] q[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic xfer(input logic [7:0] f[$], input logic [7:0] e[$]);
    int k;
    u_host.got.delete();
    u_host.send(f);
    co2_mean_float = ~co2_mean_float;
    for (k = 0; k < 200 && u_host.got.size() < e.size(); k++) @(negedge ref_clk);
    repeat (12) @(negedge ref_clk);
    tests_run++;
    if (u_host.got.size() < e.size()) begin
      mismatches++;
      $display("wrong value at %0t: reply timed out", $time);
      wrap_up();
    end
    if (u_host.got.size() != e.size()) begin
      mismatches++;
      $display("wrong value at %0t: reply length", $time);
    end
    foreach (e[i]) begin
      if (u_host.got[i] !== e[i]) begin
        mismatches++;
        $display("wrong value at %0t: reply byte %0d", $time, i);
      end
    end
  endtask
  task automatic t_exc();
    logic [7:0] f[$];
    logic [7:0] e[$];
    f = '{8'h43, 8'h04, 8'h04, 8'h24, 8'h00, 8'h02};
    add_crc(f);
    e = '{8'h43, 8'h84, EXC_BAD_FUNC};
    add_crc(e);
    xfer(f, e);
    f = '{8'h43, 8'h03, 8'h04, 8'h26, 8'h00, 8'h02};
    add_crc(f);
    e = '{8'h43, 8'h83, EXC_BAD_ADDR};
    add_crc(e);
    xfer(f, e);
    f = '{8'h43, 8'h03, 8'h04, 8'h24, 8'h00, 8'h01};
    add_crc(f);
    xfer(f, e);
    xfer('{8'h43, 8'h03, 8'h04, 8'h24, 8'h00, 8'h02, 8'h8a, 8'h12, 8'h00}, '{});
    xfer('{8'h43, 8'h03, 8'h04, 8'h24, 8'h00, 8'h02, 8'h8a}, '{});
    $display("t_exc end");
  endtask
  task automatic t_read();
    logic [7:0] e[$] = '{8'h43, FC_READ_HOLD, FLOAT_BYTES, 8'h0b, 8'h00, 8'h44, 8'ha1};
    add_crc(e);
    co2_mean_float = 32'h44a10b00;
    xfer('{8'h43, 8'h03, 8'h04, 8'h24, 8'h00, 8'h02, 8'h8a, 8'h12}, e);
    xfer('{8'h43, 8'h03, 8'h04, 8'h24, 8'h00, 8'h02, 8'h8a, 8'h13}, '{});
    $display("t_read end");
  endtask
  task automatic t_station();
    logic [7:0] f[$] = '{8'h11, 8'h03, 8'h04, 8'h24, 8'h00, 8'h02};
    logic [7:0] e[$] = '{8'h11, 8'h03, 8'h04, 8'h00, 8'h00, 8'hc2, 8'hf6};
    add_crc(f);
    add_crc(e);
    station_cfg_en = 1;
    station_cfg = 8'h11;
    co2_mean_float = 32'hc2f60000;
    xfer(f, e);
    xfer('{8'h43, 8'h03, 8'h04, 8'h24, 8'h00, 8'h02, 8'h8a, 8'h12}, '{});
    $display("t_station end");
  endtask
  initial begin
    rst = 1; station_cfg_en = 0; station_cfg = 8'h00; co2_mean_float = 32'h0;
    repeat (2) @(negedge ref_clk);
    rst = 0;
    t_read();
    t_exc();
    t_station();
    wrap_up();
  end
endmodule
`default_nettype wire
